/* verilog/ifsw_pkg.sv */
// Package for the IF switch select control: constants, types, carriers.
package ifsw_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 4;
    localparam int NUM_RF_IN = 8;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SELECT = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h0C;

    // Control register fields
    localparam int CTRL_ENV_POS = 0;      // 4 bits, envelope mode per chan
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int STAT_MSG_POS = 0;      // 4 bits, message control per chan
    localparam int STAT_CASC_POS = 4;     // chained inputs enabled
    localparam int STAT_MODE_POS = 8;     // 2 bits, decoded mode

    // Config register fields
    localparam int CFG_GAIN_POS = 0;      // 2 bits, applied gain

    // Selector codes: 0..7 rf_input 1..8, 8 chained input
    localparam logic [3:0] SEL_CASCADE = 4'h8;
    localparam logic [3:0] SEL_RESET = 4'h0;

    // Switch state nibble bit positions (band, polarization, position,
    // option)
    localparam int SW_BAND = 0;
    localparam int SW_POL = 1;
    localparam int SW_POS = 2;
    localparam int SW_OPT = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IFSW_MODE_LNB = 2'b00,
        IFSW_MODE_SLAVE = 2'b01,
        IFSW_MODE_MASTER = 2'b10,
        IFSW_MODE_SINGLE = 2'b11
    } ifsw_mode_e;

    typedef enum logic [1:0] {
        IFSW_GAIN_0DB = 2'b00,
        IFSW_GAIN_6DB = 2'b01,
        IFSW_GAIN_12DB = 2'b10
    } ifsw_gain_e;

    localparam ifsw_gain_e GAIN_RESET = IFSW_GAIN_0DB;

    // Message class from the channel's serial decoder
    typedef enum logic [0:0] {
        IFSW_MSG_LNB = 1'b0,
        IFSW_MSG_MULTI = 1'b1
    } ifsw_msg_e;

    // One decoded serial control message
    typedef struct packed {
        logic valid;
        ifsw_msg_e cls;
        logic [3:0] sw;
    } ifsw_msg_s;

    // Voltage/tone levels of one channel
    typedef struct packed {
        logic volt_hi;   // high supply voltage: horizontal
        logic tone_on;   // tone present: high band
    } ifsw_vt_s;

endpackage

/* verilog/ifsw_ctrl.sv */
// IF switch select control: mode/gain decode and four output selectors.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// - Four selectors, each picks one of nine sources, driven by own receiver.
// - Master mode enables the four chained inputs for selection.
// - LNB, slave and single modes keep chained inputs disabled.
// - LNB mode honours LNB messages and ignores multiswitch messages.
// - Single mode honours multiswitch messages and ignores LNB messages.
// - Mode code: LNB, slave, master, single from the four pin levels.
// - One common gain for all inputs: 0dB, +6dB or +12dB.
// - Power-up, or receiver connection with no honoured message in that cycle, puts channel in voltage/tone control.
// - A received message moves only that channel to message control.
// - Return output carries reply signalling or received control envelope.
// - After reset every selector picks input one of the primary device.
module ifsw_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Static configuration, already quantised
    input wire logic [1:0] mode_code,
    input wire logic [1:0] gain_code,
    // Per-channel receiver side
    input wire logic [3:0] rx_connect,
    input wire logic [3:0] control_signal_in,
    input wire logic [3:0] reply_signal,
    input wire ifsw_pkg::ifsw_vt_s [3:0] vt_level,
    input wire ifsw_pkg::ifsw_msg_s [3:0] msg_in,
    // Switch and gain controls
    output logic [3:0] rf_output_sel [4],
    output logic cascade_en,
    output ifsw_pkg::ifsw_gain_e input_gain,
    output logic [3:0] return_signal_out,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Switch nibble to selector code; option B needs chained inputs
    function automatic logic [3:0] sw_to_sel(input logic [3:0] sw,
                                             input logic casc);
        logic [3:0] code;
        code = {1'b0, sw[ifsw_pkg::SW_POS], sw[ifsw_pkg::SW_BAND],
                sw[ifsw_pkg::SW_POL]};
        if (sw[ifsw_pkg::SW_OPT] && casc) begin
            code = ifsw_pkg::SEL_CASCADE;
        end
        return code;
    endfunction

    // Does the current mode honour this message class
    function automatic logic msg_accept(input ifsw_pkg::ifsw_mode_e m,
                                        input ifsw_pkg::ifsw_msg_e c);
        logic ok;
        ok = 1'b1;
        unique case (m)
            ifsw_pkg::IFSW_MODE_LNB: begin
                ok = (c == ifsw_pkg::IFSW_MSG_LNB);
            end
            ifsw_pkg::IFSW_MODE_SINGLE: begin
                ok = (c == ifsw_pkg::IFSW_MSG_MULTI);
            end
            ifsw_pkg::IFSW_MODE_SLAVE,
            ifsw_pkg::IFSW_MODE_MASTER: begin
                ok = 1'b1;
            end
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    ifsw_pkg::ifsw_mode_e mode_r;
    ifsw_pkg::ifsw_gain_e gain_r;
    logic casc_r;
    logic casc_nxt;

    // Shared by the enable and the selectors so both move on one edge
    assign casc_nxt = (mode_code == ifsw_pkg::IFSW_MODE_MASTER);

    // Mode sampled every cycle; the pin is static so no filter is needed
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= ifsw_pkg::IFSW_MODE_LNB;
            casc_r <= 1'b0;
        end else begin
            mode_r <= ifsw_pkg::ifsw_mode_e'(mode_code);
            casc_r <= casc_nxt;
        end
    end

    // Common gain; the unused code keeps the last legal setting
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_r <= ifsw_pkg::GAIN_RESET;
        end else begin
            unique case (gain_code)
                2'b00: gain_r <= ifsw_pkg::IFSW_GAIN_0DB;
                2'b01: gain_r <= ifsw_pkg::IFSW_GAIN_6DB;
                2'b10: gain_r <= ifsw_pkg::IFSW_GAIN_12DB;
                default: gain_r <= gain_r;
            endcase
        end
    end

    assign cascade_en = casc_r;
    assign input_gain = gain_r;

    // ------------------------------------------------------------------
    // Per-channel control source
    // ------------------------------------------------------------------
    logic [3:0] msg_ctl_r;
    logic [3:0] msg_take;
    logic [3:0] sw_state_r [4];

    // A message counts only if the mode honours its class
    always_comb begin
        for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
            msg_take[i] = msg_in[i].valid && msg_accept(mode_r, msg_in[i].cls);
        end
    end

    // Connect forces voltage/tone; message in the same cycle wins since
    // it arrived from the newly connected receiver
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            msg_ctl_r <= 4'h0;
        end else begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                if (msg_take[i]) begin
                    msg_ctl_r[i] <= 1'b1;
                end else if (rx_connect[i]) begin
                    msg_ctl_r[i] <= 1'b0;
                end
            end
        end
    end

    // Last accepted switch nibble per channel
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                sw_state_r[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                if (msg_take[i]) begin
                    sw_state_r[i] <= msg_in[i].sw;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output selectors
    // ------------------------------------------------------------------
    logic [3:0] sel_r [4];
    logic [3:0] sel_nxt [4];

    // Voltage/tone reaches position A only; messages reach all nine in master mode, the eight rf inputs otherwise
    always_comb begin
        for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
            if (msg_ctl_r[i]) begin
                sel_nxt[i] = sw_to_sel(sw_state_r[i], casc_nxt);
            end else begin
                sel_nxt[i] = {2'b00, vt_level[i].tone_on,
                              vt_level[i].volt_hi};
            end
        end
    end

    // Registered so that a mode change never glitches the mux
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                sel_r[i] <= ifsw_pkg::SEL_RESET;
            end
        end else begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    assign rf_output_sel = sel_r;

    // ------------------------------------------------------------------
    // Return outputs
    // ------------------------------------------------------------------
    logic [3:0] env_mode_r;
    logic [3:0] ret_r;

    // Envelope or reply per channel, software chooses
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ret_r <= 4'h0;
        end else begin
            for (int i = 0; i < ifsw_pkg::NUM_CHAN; i++) begin
                ret_r[i] <= env_mode_r[i] ? control_signal_in[i]
                                          : reply_signal[i];
            end
        end
    end

    assign return_signal_out = ret_r;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;

    // Control register write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            env_mode_r <= ifsw_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == ifsw_pkg::OFS_CTRL) begin
            env_mode_r <= reg_wdata[ifsw_pkg::CTRL_ENV_POS +: 4];
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr)
            ifsw_pkg::OFS_CTRL: begin
                rd_mux[ifsw_pkg::CTRL_ENV_POS +: 4] = env_mode_r;
            end
            ifsw_pkg::OFS_STATUS: begin
                rd_mux[ifsw_pkg::STAT_MSG_POS +: 4] = msg_ctl_r;
                rd_mux[ifsw_pkg::STAT_CASC_POS] = casc_r;
                rd_mux[ifsw_pkg::STAT_MODE_POS +: 2] = mode_r;
            end
            ifsw_pkg::OFS_SELECT: begin
                rd_mux[15:0] = {sel_r[3], sel_r[2], sel_r[1], sel_r[0]};
            end
            ifsw_pkg::OFS_CONFIG: begin
                rd_mux[ifsw_pkg::CFG_GAIN_POS +: 2] = gain_r;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;

endmodule // ifsw_ctrl

/* testbench/ifsw_ctrl_assertions.sv */
// Port checker for the IF switch select control.
`timescale 1ns/100ps
module ifsw_ctrl_checker (
    // Clock, reset and configuration
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [1:0] mode_code,
    input wire logic [1:0] gain_code,
    // Receiver side
    input wire logic [3:0] rx_connect,
    input wire logic [3:0] control_signal_in,
    input wire logic [3:0] reply_signal,
    input wire ifsw_pkg::ifsw_vt_s [3:0] vt_level,
    input wire ifsw_pkg::ifsw_msg_s [3:0] msg_in,
    // Outputs watched
    input wire logic [3:0] rf_output_sel [4],
    input wire logic cascade_en,
    input wire ifsw_pkg::ifsw_gain_e input_gain,
    input wire logic [3:0] return_signal_out,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic c0;
    logic ok0;
    // Channel 0 message that the mode honours
    assign c0 = msg_in[0].cls;
    assign ok0 = msg_in[0].valid && !(mode_code == 2'h0 && c0)
        && !(mode_code == 2'h3 && !c0);
    a_casc_mode: assert property (reset_n |=>
        cascade_en == ($past(mode_code) == 2'h2))
        else $error("chained enable wrong for mode");
    a_casc_blocked: assert property (!cascade_en |->
        rf_output_sel[0] != 4'h8 && rf_output_sel[1] != 4'h8
        && rf_output_sel[2] != 4'h8 && rf_output_sel[3] != 4'h8)
        else $error("chained input routed while disabled");
    a_gain_set: assert property (reset_n && gain_code != 2'h3 |=>
        input_gain == $past(gain_code)) else $error("gain not applied");
    a_gain_hold: assert property (gain_code == 2'h3 |=>
        $stable(input_gain)) else $error("gain moved on code 3");
    a_msg_sel: assert property (ok0 && !msg_in[0].sw[3] |->
        ##2 rf_output_sel[0] == {1'b0, $past(msg_in[0].sw[2], 2),
        $past(msg_in[0].sw[0], 2), $past(msg_in[0].sw[1], 2)})
        else $error("message did not set selector");
    a_casc_pick: assert property (ok0 && msg_in[0].sw[3] &&
        cascade_en |-> ##2 rf_output_sel[0] == 4'h8)
        else $error("chained input not picked");
    a_vt_sel: assert property (rx_connect[0] &&
        !msg_in[0].valid ##1 !msg_in[0].valid |=> rf_output_sel[0] ==
        {2'b00, $past(vt_level[0].tone_on), $past(vt_level[0].volt_hi)})
        else $error("voltage/tone select wrong");
    a_ret_path: assert property (##1 ((return_signal_out ^
        $past(reply_signal)) & ~($past(control_signal_in)
        ^ $past(reply_signal))) == 4'h0) else $error("return path wrong");
    a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    // Main scenarios reached
    cover property (cascade_en && rf_output_sel[0] == 4'h8);
    cover property (ok0);
    cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule // ifsw_ctrl_checker

bind ifsw_ctrl ifsw_ctrl_checker ifsw_ctrl_checker_i (
    .core_clk, .reset_n, .mode_code, .gain_code, .rx_connect,
    .control_signal_in, .reply_signal, .vt_level, .msg_in,
    .rf_output_sel, .cascade_en, .input_gain, .return_signal_out,
    .reg_rd, .reg_rdata);

/* testbench/ifsw_rx_model.sv */
// Receiver model: voltage/tone, decoded messages, return-path inputs.
`timescale 1ns/100ps
module ifsw_rx_model (
    // Clock
    input wire logic core_clk,
    // Signalling toward the switch
    output logic [3:0] rx_connect,
    output logic [3:0] control_signal_in,
    output logic [3:0] reply_signal,
    output ifsw_pkg::ifsw_vt_s [3:0] vt_level,
    output ifsw_pkg::ifsw_msg_s [3:0] msg_in
);
    // Idle lines; message fields junk since nothing qualifies them
    initial begin
        rx_connect = 4'h0;
        control_signal_in = 4'h0;
        reply_signal = 4'h0;
        vt_level = '0;
        msg_in = {4{6'h15}};
    end
    // One-cycle message; fields inverted after so stale data never match
    task send_msg(input int ch, input logic c, input logic [3:0] sw);
        @(posedge core_clk);
        msg_in[ch] <= {1'b1, c, sw};
        @(posedge core_clk);
        msg_in[ch] <= {1'b0, ~c, ~sw};
    endtask
    // Voltage and tone levels of one receiver
    task set_vt(input int ch, input logic t, input logic v);
        @(posedge core_clk);
        vt_level[ch] <= {v, t};
    endtask
    // Receiver plugged in again
    task connect(input int ch);
        @(posedge core_clk);
        rx_connect[ch] <= 1'b1;
        @(posedge core_clk);
        rx_connect[ch] <= 1'b0;
    endtask
    // Control envelope and reply bits
    task set_ret(input logic [3:0] c, input logic [3:0] r);
        @(posedge core_clk);
        control_signal_in <= c;
        reply_signal <= r;
    endtask
endmodule // ifsw_rx_model

/* testbench/ifsw_ctrl_tb_top.sv */
// Self-checking bench for the IF switch select control.
`timescale 1ns/100ps
module ifsw_ctrl_tb_top;
    logic core_clk, reset_n, cascade_en, reg_wr, reg_rd;
    logic [1:0] mode_code, gain_code;
    logic [3:0] rx_connect, control_signal_in, reply_signal;
    logic [3:0] return_signal_out;
    ifsw_pkg::ifsw_vt_s [3:0] vt_level;
    ifsw_pkg::ifsw_msg_s [3:0] msg_in;
    logic [3:0] rf_output_sel [4];
    ifsw_pkg::ifsw_gain_e input_gain;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    // Rows: mode[7:6] gain code[5:4] gain expected[3:2] tone[1] volt[0]
    logic [7:0] rows [4];
    int fail_count, n_compared;

    ifsw_ctrl ifsw_ctrl_i (.core_clk, .reset_n, .mode_code, .gain_code,
        .rx_connect, .control_signal_in, .reply_signal, .vt_level,
        .msg_in, .rf_output_sel, .cascade_en, .input_gain,
        .return_signal_out, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);
    ifsw_rx_model rxm (.core_clk, .rx_connect, .control_signal_in,
        .reply_signal, .vt_level, .msg_in);

    // ------------------------------------------------------------
    // Clock, helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task chk(input logic ok);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t value mismatch", $time);
        end
    endtask
    // Settle just past the edge so sampling never races the design
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task do_reset(input logic [1:0] m);
        @(posedge core_clk);
        reset_n <= 1'b0;
        mode_code <= m;
        tick(16);
        for (int i = 0; i < 4; i++) chk(rf_output_sel[i] === 4'h0);
        @(posedge core_clk);
        reset_n <= 1'b1;
        tick(2);
    endtask
    task finish_test;
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the 140 or so cycles needed
    initial begin
        #200000;
        fail_count++;
        finish_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, reg_wr, reg_rd, mode_code, gain_code} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        fail_count = 0;
        n_compared = 0;
        rows = '{8'h02, 8'h55, 8'hAB, 8'hFA};
        do_reset(2'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            mode_code <= rows[i][7:6];
            gain_code <= rows[i][5:4];
            rxm.set_vt(i, rows[i][1], rows[i][0]);
            tick(2);
            chk(cascade_en === (rows[i][7:6] == 2'h2));
            chk(input_gain === rows[i][3:2]);
            chk(rf_output_sel[i] === {2'b00, rows[i][1:0]});
            rd(ifsw_pkg::OFS_STATUS);
            chk(d[9:8] === rows[i][7:6]);
        end
        // Single mode: class filter, per-channel message control
        rxm.send_msg(0, 1'b0, 4'h6);
        tick(2);
        chk(rf_output_sel[0] === 4'h2);
        rxm.send_msg(0, 1'b1, 4'h6);
        tick(2);
        chk(rf_output_sel[0] === 4'h5);
        rxm.set_vt(0, 1'b0, 1'b1);
        rxm.send_msg(1, 1'b1, 4'hD);
        tick(2);
        chk(rf_output_sel[0] === 4'h5);
        chk(rf_output_sel[1] === 4'h6);
        rd(ifsw_pkg::OFS_STATUS);
        chk(d[4:0] === 5'h03);
        rxm.connect(0);
        tick(2);
        chk(rf_output_sel[0] === 4'h1);
        rd(ifsw_pkg::OFS_STATUS);
        chk(d[3:0] === 4'h2);
        // LNB mode drops multiswitch class
        do_reset(2'h0);
        rxm.send_msg(0, 1'b1, 4'h6);
        tick(2);
        chk(rf_output_sel[0] === 4'h1);
        rxm.send_msg(0, 1'b0, 4'h6);
        tick(2);
        chk(rf_output_sel[0] === 4'h5);
        // Mid-run reset clears selectors, then master routes chained input
        do_reset(2'h2);
        rxm.send_msg(0, 1'b1, 4'hD);
        tick(2);
        chk(rf_output_sel[0] === ifsw_pkg::SEL_CASCADE);
        // Return path and register port, read-only and unmapped places
        wr(ifsw_pkg::OFS_CTRL, 32'h5);
        rxm.set_ret(4'hF, 4'h0);
        tick(2);
        chk(return_signal_out === 4'h5);
        rd(ifsw_pkg::OFS_CTRL);
        chk(d === 32'h0000_0005);
        wr(ifsw_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        rd(ifsw_pkg::OFS_STATUS);
        chk(d === 32'h0000_0211);
        rd(8'h10);
        chk(d === 32'h0);
        // Code 3 since the last reset: the reset gain is kept
        rd(ifsw_pkg::OFS_CONFIG);
        chk(d === 32'h0000_0000);
        // Channel 0 chained, others from their voltage/tone levels
        rd(ifsw_pkg::OFS_SELECT);
        chk(d === 32'h0000_2318);
        finish_test;
    end
endmodule // ifsw_ctrl_tb_top
